// File: hdl/rtc_averager.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_averager (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic sample_valid_i,
   input wire logic [15:0] sample_i,
   input wire logic [2:0] depth_i,
   output logic [15:0] avg_o
);
   logic [15:0] hist [32];
   logic [4:0] wp;
   logic [5:0] fill;
   logic [20:0] sum;
   logic [2:0] depth_q;
   logic [5:0] win;
   logic [15:0] oldest;
   logic [20:0] next_sum;
   logic [20:0] shifted;

   always_comb begin
      win = 6'h01 << depth_i;
      oldest = hist[wp - win[4:0]];
      if (fill >= win) begin
         next_sum = sum + {5'h00, sample_i} - {5'h00, oldest};
      end else begin
         next_sum = sum + {5'h00, sample_i};
      end
      shifted = next_sum >> depth_i;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sample_valid_i) begin
         hist[wp] <= sample_i;
      end
   end

   // a depth change restarts the window instead of mixing sizes
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp <= 5'h00;
         fill <= 6'h00;
         sum <= 21'h000000;
         depth_q <= 3'h0;
         avg_o <= 16'h0000;
      end else if (depth_q != depth_i) begin
         depth_q <= depth_i;
         fill <= 6'h00;
         sum <= 21'h000000;
      end else if (sample_valid_i) begin
         wp <= wp + 5'h01;
         sum <= next_sum;
         avg_o <= shifted[15:0];
         if (fill < win) begin
            fill <= fill + 6'h01;
         end
      end
   end
endmodule : rtc_averager
`default_nettype wire

// File: hdl/rtc_config_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module rtc_config_core #(
   parameter int unsigned TXN_LIMIT = `RTC_TXN_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic txn_start_i,
   input wire logic txn_write_i,
   input wire logic [7:0] txn_cmd_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_byte_i,
   input wire logic txn_stop_i,
   input wire logic rd_req_i,
   output logic rd_valid_o,
   output logic [7:0] rd_byte_o,
   output logic txn_error_o,
   input wire logic nvm_load_i,
   input wire logic [7:0] nvm_regulator_i,
   input wire logic [47:0] nvm_telemetry_i,
   output logic [3:0] regulator_voltage_select_o,
   output logic adc_start_o,
   output logic [1:0] adc_channel_o,
   input wire logic adc_done_i,
   input wire logic [15:0] adc_data_i,
   output logic [15:0] read_vout_o,
   output logic [15:0] read_iout_o,
   output logic [15:0] read_temp_o,
   output logic [15:0] read_vin_o
);
   logic [39:0] tel_cfg;
   logic txn_open;
   logic txn_wr;
   logic [7:0] txn_cmd;
   logic [7:0] cnt_byte;
   logic [2:0] byte_idx;
   logic [2:0] rd_idx;
   logic [47:0] wbuf;
   logic [31:0] txn_age;
   logic [2:0] exp_len;
   logic [47:0] rd_word;
   logic timeout;
   logic commit;
   logic code_ok;
   logic [3:0] wr_code;
   logic [1:0] pri [4];
   logic [2:0] depth [4];
   logic [3:0] mask_a;
   logic [3:0] mask_b;
   logic [3:0] mask_c;
   logic [15:0] avg [4];
   logic [15:0] tele [4];
   rtc_pkg::rtc_sched_t state;
   rtc_pkg::rtc_sched_t next_state;
   logic [2:0] pa;
   logic [2:0] pb;
   logic [2:0] pc;
   logic [2:0] next_pa;
   logic [2:0] next_pb;
   logic [2:0] next_pc;
   logic next_found;
   logic [1:0] next_ch;
   logic [2:0] fa;
   logic [2:0] fb;
   logic [2:0] fb0;
   logic [2:0] fc;
   logic [2:0] fc0;
   logic last_lower;

   default clocking rtc_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // lowest channel index at or above ptr with its mask bit set
   function automatic logic [2:0] find_from(input logic [3:0] m,
                                            input logic [2:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i] && ({1'b0, 2'(i)} >= p)) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction : find_from

   always_comb begin
      exp_len = 3'h0;
      if (txn_cmd == `RTC_CMD_REGULATOR) begin
         exp_len = `RTC_LEN_REGULATOR;
      end else if (txn_cmd == `RTC_CMD_TELEMETRY) begin
         exp_len = `RTC_LEN_TELEMETRY;
      end
   end

   always_comb begin
      if (txn_cmd == `RTC_CMD_REGULATOR) begin
         rd_word = {40'h00_0000_0000, regulator_voltage_select_o, 4'h0};
      end else begin
         rd_word = {8'h00, tel_cfg};
      end
   end

   assign timeout = txn_open && (txn_age >= TXN_LIMIT);
   assign wr_code = wbuf[`RTC_SEL_LSB +: 4];
   assign code_ok = (wr_code >= `RTC_SEL_MIN) && (wr_code <= `RTC_SEL_MAX);
   assign commit = txn_open && txn_wr && txn_stop_i && !timeout &&
                   (exp_len != 3'h0) && (cnt_byte == {5'h00, exp_len}) &&
                   (byte_idx == exp_len + 3'h1);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txn_open <= 1'b0;
         txn_wr <= 1'b0;
         txn_cmd <= 8'h00;
         byte_idx <= 3'h0;
         rd_idx <= 3'h0;
         txn_age <= 32'h0000_0000;
      end else if (txn_start_i) begin
         txn_open <= 1'b1;
         txn_wr <= txn_write_i;
         txn_cmd <= txn_cmd_i;
         byte_idx <= 3'h0;
         rd_idx <= 3'h0;
         txn_age <= 32'h0000_0000;
      end else if (txn_open && (txn_stop_i || timeout)) begin
         txn_open <= 1'b0;
      end else if (txn_open) begin
         txn_age <= txn_age + 32'h0000_0001;
         if (wr_valid_i && txn_wr && byte_idx != 3'h7) begin
            byte_idx <= byte_idx + 3'h1;
         end
         if (rd_req_i && !txn_wr && rd_idx != 3'h7) begin
            rd_idx <= rd_idx + 3'h1;
         end
      end
   end

   // first byte is the count, data follows low byte first
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_byte <= 8'h00;
         wbuf <= 48'h0000_0000_0000;
      end else if (txn_start_i) begin
         cnt_byte <= 8'h00;
      end else if (txn_open && txn_wr && wr_valid_i) begin
         if (byte_idx == 3'h0) begin
            cnt_byte <= wr_byte_i;
         end
         for (int k = 0; k < 6; k++) begin
            if (byte_idx == 3'(k + 1)) begin
               wbuf[8 * k +: 8] <= wr_byte_i;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_valid_o <= 1'b0;
         rd_byte_o <= 8'h00;
      end else begin
         rd_valid_o <= 1'b0;
         if (txn_open && !txn_wr && rd_req_i && !txn_start_i) begin
            rd_valid_o <= 1'b1;
            rd_byte_o <= 8'hff;
            if (rd_idx == 3'h0) begin
               rd_byte_o <= {5'h00, exp_len};
            end
            for (int k = 0; k < 6; k++) begin
               if (rd_idx == 3'(k + 1) && rd_idx <= exp_len) begin
                  rd_byte_o <= rd_word[8 * k +: 8];
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txn_error_o <= 1'b0;
      end else begin
         txn_error_o <= 1'b0;
         if (txn_open && !txn_start_i) begin
            if (timeout) begin
               txn_error_o <= 1'b1;
            end else if (txn_wr && txn_stop_i) begin
               txn_error_o <= !commit ||
                  (txn_cmd == `RTC_CMD_REGULATOR && !code_ok);
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         regulator_voltage_select_o <= `RTC_RST_SEL;
      end else if (nvm_load_i) begin
         regulator_voltage_select_o <= nvm_regulator_i[`RTC_SEL_LSB +: 4];
      end else if (commit && txn_cmd == `RTC_CMD_REGULATOR && code_ok) begin
         regulator_voltage_select_o <= wr_code;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tel_cfg <= `RTC_RST_TELEMETRY;
      end else if (nvm_load_i) begin
         tel_cfg <= nvm_telemetry_i[39:0];
      end else if (commit && txn_cmd == `RTC_CMD_TELEMETRY) begin
         tel_cfg <= wbuf[39:0];
      end
   end

   always_comb begin
      pri[0] = tel_cfg[`RTC_VO_LSB + `RTC_PRI_OFS +: 2];
      pri[1] = tel_cfg[`RTC_IO_LSB + `RTC_PRI_OFS +: 2];
      pri[2] = tel_cfg[`RTC_TMP_LSB + `RTC_PRI_OFS +: 2];
      pri[3] = tel_cfg[`RTC_VI_LSB + `RTC_PRI_OFS +: 2];
      depth[0] = tel_cfg[`RTC_VO_LSB +: 3];
      depth[1] = tel_cfg[`RTC_IO_LSB +: 3];
      depth[2] = tel_cfg[`RTC_TMP_LSB +: 3];
      depth[3] = tel_cfg[`RTC_VI_LSB +: 3];
      for (int i = 0; i < 4; i++) begin
         // invalid depth clamps to the deepest window
         if (depth[i] > `RTC_DEPTH_MAX) begin
            depth[i] = `RTC_DEPTH_MAX;
         end
         mask_a[i] = pri[i] == rtc_pkg::rtc_tier_a;
         mask_b[i] = pri[i] == rtc_pkg::rtc_tier_b;
         mask_c[i] = pri[i] == rtc_pkg::rtc_tier_c;
      end
      // overtemperature needs it, so the off code runs top tier
      if (pri[`RTC_CH_TEMP] == `RTC_PRI_OFF) begin
         mask_a[`RTC_CH_TEMP] = 1'b1;
      end
   end

   always_comb begin
      fa = find_from(mask_a, pa);
      fb = find_from(mask_b, pb);
      fb0 = find_from(mask_b, 3'h0);
      fc = find_from(mask_c, pc);
      fc0 = find_from(mask_c, 3'h0);
      next_found = 1'b0;
      next_ch = 2'h0;
      next_pa = pa;
      next_pb = pb;
      next_pc = pc;
      next_state = state;
      case (state)
         rtc_pkg::rtc_pick_a: begin
            if (fa[2]) begin
               next_found = 1'b1;
               next_ch = fa[1:0];
               next_pa = {1'b0, fa[1:0]} + 3'h1;
            end else begin
               next_pa = 3'h0;
               next_state = rtc_pkg::rtc_pick_b;
            end
         end
         rtc_pkg::rtc_pick_b: begin
            // end of a middle pass is one lowest-tier slot
            if (fb[2]) begin
               next_found = 1'b1;
               next_ch = fb[1:0];
               next_pb = {1'b0, fb[1:0]} + 3'h1;
            end else if (fc0[2]) begin
               next_found = 1'b1;
               next_pb = 3'h0;
               next_ch = fc[2] ? fc[1:0] : fc0[1:0];
               next_pc = {1'b0, next_ch} + 3'h1;
            end else if (fb0[2]) begin
               next_found = 1'b1;
               next_ch = fb0[1:0];
               next_pb = {1'b0, fb0[1:0]} + 3'h1;
            end
            if (!next_found) begin
               next_state = rtc_pkg::rtc_pick_a;
            end
         end
         rtc_pkg::rtc_wait: begin
            if (adc_done_i) begin
               next_state = rtc_pkg::rtc_pick_a;
            end
         end
         default: begin
            next_state = rtc_pkg::rtc_pick_a;
         end
      endcase
      if (next_found) begin
         next_state = rtc_pkg::rtc_wait;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= rtc_pkg::rtc_pick_a;
         pa <= 3'h0;
         pb <= 3'h0;
         pc <= 3'h0;
         adc_start_o <= 1'b0;
         adc_channel_o <= 2'h0;
      end else begin
         state <= next_state;
         pa <= next_pa;
         pb <= next_pb;
         pc <= next_pc;
         adc_start_o <= next_found;
         if (next_found) begin
            adc_channel_o <= next_ch;
         end
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_avg
      rtc_averager u_avg (
         .sys_clk_i(sys_clk_i),
         .rst_b_i(rst_b_i),
         .sample_valid_i(adc_done_i && state == rtc_pkg::rtc_wait &&
                         adc_channel_o == 2'(g)),
         .sample_i(adc_data_i),
         .depth_i(depth[g]),
         .avg_o(avg[g])
      );
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            tele[g] <= 16'h0000;
         end else if (pri[g] == `RTC_PRI_OFF && g != `RTC_CH_TEMP) begin
            tele[g] <= 16'h0000;
         end else begin
            tele[g] <= avg[g];
         end
      end
   end

   assign read_vout_o = tele[0];
   assign read_iout_o = tele[1];
   assign read_temp_o = tele[2];
   assign read_vin_o = tele[3];

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_lower <= 1'b0;
      // classed at the pick, under the mask that chose it
      end else if (next_found) begin
         last_lower <= !mask_a[next_ch];
      end
   end

   AST_REG_APPLY: assert property (
      commit && txn_cmd == `RTC_CMD_REGULATOR && code_ok && !nvm_load_i
      |=> regulator_voltage_select_o == $past(wr_code))
      else $error("valid regulator code not applied");
   AST_REG_HOLD: assert property (
      commit && !code_ok && !nvm_load_i
      |=> $stable(regulator_voltage_select_o))
      else $error("invalid regulator code changed setting");
   AST_TXN_DONE: assert property (
      txn_open |-> txn_age <= TXN_LIMIT)
      else $error("transaction held past time limit");
   AST_COUNT_BYTE: assert property (
      txn_open && !txn_wr && rd_req_i && !txn_start_i && rd_idx == 3'h0
      |=> rd_valid_o && rd_byte_o == {5'h00, $past(exp_len)})
      else $error("block read count byte wrong");
   AST_RSVD_NIBBLE: assert property (
      txn_open && !txn_wr && rd_req_i && rd_idx == 3'h1 && !txn_start_i &&
      txn_cmd == `RTC_CMD_REGULATOR |=> rd_byte_o[3:0] == 4'h0)
      else $error("regulator reserved bits not zero");
   AST_TOP_BYTE: assert property (
      txn_open && !txn_wr && rd_req_i && rd_idx == 3'h6 && !txn_start_i &&
      txn_cmd == `RTC_CMD_TELEMETRY |=> rd_byte_o == 8'h00)
      else $error("telemetry top byte not zero");
   AST_OFF_ZERO: assert property (
      pri[0] == `RTC_PRI_OFF ##1 pri[0] == `RTC_PRI_OFF
      |-> read_vout_o == 16'h0000)
      else $error("disabled channel not zero");
   AST_TEMP_ON: assert property (
      pri[`RTC_CH_TEMP] == `RTC_PRI_OFF |-> mask_a[`RTC_CH_TEMP])
      else $error("temperature channel dropped");
   AST_A_FIRST: assert property (
      state == rtc_pkg::rtc_pick_a && fa[2]
      |=> adc_start_o && adc_channel_o == $past(fa[1:0]))
      else $error("top tier not measured first");
   AST_ONE_SLOT: assert property (
      next_found && last_lower && mask_a != 4'h0 |-> mask_a[next_ch])
      else $error("two lower-tier slots in a row");
   AST_C_AFTER_B: assert property (
      state == rtc_pkg::rtc_pick_b && fb[2]
      |=> adc_start_o && adc_channel_o == $past(fb[1:0]))
      else $error("lowest tier taken before middle pass end");
   AST_ONE_ADC: assert property (
      adc_start_o |=> !adc_start_o until adc_done_i)
      else $error("converter started while busy");
   AST_DEPTH_OK: assert property (
      depth[0] <= `RTC_DEPTH_MAX && depth[3] <= `RTC_DEPTH_MAX)
      else $error("average depth out of range");
endmodule : rtc_config_core
`default_nettype wire

// File: hdl/rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_CMD_REGULATOR 8'hb5
`define RTC_CMD_TELEMETRY 8'hd0
`define RTC_LEN_REGULATOR 3'h1
`define RTC_LEN_TELEMETRY 3'h6
`define RTC_SEL_LSB 4
`define RTC_SEL_MIN 4'h3
`define RTC_SEL_MAX 4'ha
`define RTC_RST_SEL 4'h9
`define RTC_RST_TELEMETRY 40'h03_0000_0000
`define RTC_VO_LSB 0
`define RTC_IO_LSB 8
`define RTC_TMP_LSB 16
`define RTC_VI_LSB 24
`define RTC_PRI_OFS 6
`define RTC_DEPTH_MAX 3'h5
`define RTC_CH_TEMP 2'h2
`define RTC_PRI_OFF 2'h3
`define RTC_CLK_PERIOD_NS 10
`define RTC_TXN_TIME_US 1000
`define RTC_TXN_CYCLES ((`RTC_TXN_TIME_US * 1000) / `RTC_CLK_PERIOD_NS)
`define RTC_ACT_TIME_US 1000
`define RTC_ACT_CYCLES ((`RTC_ACT_TIME_US * 1000) / `RTC_CLK_PERIOD_NS)
`endif

// File: hdl/rtc_pkg.sv
package rtc_pkg;
   typedef enum logic [2:0] {
      rtc_pick_a = 3'b001,
      rtc_pick_b = 3'b010,
      rtc_wait = 3'b100
   } rtc_sched_t;
   typedef enum logic [1:0] {
      rtc_tier_a = 2'b00,
      rtc_tier_b = 2'b01,
      rtc_tier_c = 2'b10,
      rtc_tier_off = 2'b11
   } rtc_tier_t;
endpackage : rtc_pkg

// File: verification/regulator_and_telemetry_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module regulator_and_telemetry_config_bench;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic txn_start_i = 1'b0;
   logic txn_write_i = 1'b0;
   logic [7:0] txn_cmd_i = 8'h00;
   logic wr_valid_i = 1'b0;
   logic [7:0] wr_byte_i = 8'h00;
   logic txn_stop_i = 1'b0;
   logic rd_req_i = 1'b0;
   logic nvm_load_i = 1'b0;
   logic [7:0] nvm_regulator_i = 8'h00;
   logic [47:0] nvm_telemetry_i = 48'h0;
   logic slow = 1'b0;
   logic rd_valid_o, txn_error_o, adc_start_o, adc_done_i;
   logic [7:0] rd_byte_o;
   logic [3:0] regulator_voltage_select_o;
   logic [1:0] adc_channel_o;
   logic [15:0] adc_data_i, read_vout_o, read_iout_o, read_temp_o, read_vin_o;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   rtc_config_core #(.TXN_LIMIT(50)) rtc_config_core_inst (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .txn_start_i(txn_start_i),
      .txn_write_i(txn_write_i), .txn_cmd_i(txn_cmd_i),
      .wr_valid_i(wr_valid_i), .wr_byte_i(wr_byte_i),
      .txn_stop_i(txn_stop_i), .rd_req_i(rd_req_i),
      .rd_valid_o(rd_valid_o), .rd_byte_o(rd_byte_o),
      .txn_error_o(txn_error_o), .nvm_load_i(nvm_load_i),
      .nvm_regulator_i(nvm_regulator_i), .nvm_telemetry_i(nvm_telemetry_i),
      .regulator_voltage_select_o(regulator_voltage_select_o),
      .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o),
      .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
      .read_vout_o(read_vout_o), .read_iout_o(read_iout_o),
      .read_temp_o(read_temp_o), .read_vin_o(read_vin_o));
   rtc_adc_model rtc_adc_model_inst (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
      .adc_start_i(adc_start_o), .adc_channel_i(adc_channel_o),
      .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));

   task report_and_stop;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   task chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr_block(input logic [7:0] cmd, input logic [7:0] cnt,
                 input int n, input logic [47:0] data, output logic err);
      txn_start_i = 1'b1;
      txn_write_i = 1'b1;
      txn_cmd_i = cmd;
      @(negedge sys_clk_i);
      txn_start_i = 1'b0;
      wr_valid_i = 1'b1;
      for (int i = -1; i < n; i++) begin
         wr_byte_i = (i < 0) ? cnt : data[8*i +: 8];
         @(negedge sys_clk_i);
      end
      wr_valid_i = 1'b0;
      txn_stop_i = 1'b1;
      @(negedge sys_clk_i);
      txn_stop_i = 1'b0;
      err = txn_error_o;
      repeat (2) begin
         @(negedge sys_clk_i);
         err = err | txn_error_o;
      end
   endtask : wr_block

   // count byte first, then n data bytes, low byte first
   task rd_block(input logic [7:0] cmd, input int n,
                 output logic [7:0] cnt, output logic [47:0] data);
      logic seen;
      txn_start_i = 1'b1;
      txn_write_i = 1'b0;
      txn_cmd_i = cmd;
      @(negedge sys_clk_i);
      txn_start_i = 1'b0;
      data = 48'h0;
      for (int i = -1; i < n; i++) begin
         rd_req_i = 1'b1;
         @(negedge sys_clk_i);
         rd_req_i = 1'b0;
         seen = rd_valid_o;
         @(negedge sys_clk_i);
         seen = seen | rd_valid_o;
         chk(seen, 1'b1);
         if (i < 0)
            cnt = rd_byte_o;
         else
            data[8*i +: 8] = rd_byte_o;
      end
      txn_stop_i = 1'b1;
      @(negedge sys_clk_i);
      txn_stop_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
   endtask : rd_block

   task next_ch(output logic [1:0] ch);
      logic got;
      got = 1'b0;
      ch = 2'h0;
      for (int i = 0; i < 80 && !got; i++) begin
         @(negedge sys_clk_i);
         if (adc_start_o === 1'b1) begin
            got = 1'b1;
            ch = adc_channel_o;
         end
      end
      chk(got, 1'b1);
   endtask : next_ch

   task t_reset;
      logic [7:0] c;
      logic [47:0] d;
      chk(regulator_voltage_select_o, 4'h9);
      rd_block(`RTC_CMD_REGULATOR, 1, c, d);
      chk(c, 8'h01);
      chk(d, 48'h90);
      rd_block(`RTC_CMD_TELEMETRY, 6, c, d);
      chk(c, 8'h06);
      chk(d, 48'h00_03_0000_0000);
   endtask : t_reset

   task t_regulator;
      logic e;
      logic [7:0] c;
      logic [47:0] d;
      // code 3h assumes an external rail supply
      for (int k = 3; k <= 10; k++) begin
         wr_block(`RTC_CMD_REGULATOR, 8'h01, 1, {k[3:0], 4'hf}, e);
         chk(e, 1'b0);
         chk(regulator_voltage_select_o, k[3:0]);
         rd_block(`RTC_CMD_REGULATOR, 1, c, d);
         chk(d, {k[3:0], 4'h0});
      end
      wr_block(`RTC_CMD_REGULATOR, 8'h01, 1, 48'hb0, e);
      chk(e, 1'b1);
      wr_block(`RTC_CMD_REGULATOR, 8'h01, 1, 48'h20, e);
      chk(e, 1'b1);
      wr_block(`RTC_CMD_REGULATOR, 8'h02, 1, 48'h40, e);
      chk(e, 1'b1);
      chk(regulator_voltage_select_o, 4'ha);
   endtask : t_regulator

   task t_timeout;
      logic seen;
      seen = 1'b0;
      txn_start_i = 1'b1;
      txn_write_i = 1'b1;
      txn_cmd_i = `RTC_CMD_REGULATOR;
      @(negedge sys_clk_i);
      txn_start_i = 1'b0;
      repeat (60) begin
         @(negedge sys_clk_i);
         seen = seen | txn_error_o;
      end
      chk(seen, 1'b1);
   endtask : t_timeout

   task t_nvm_all_a;
      logic [7:0] c;
      logic [47:0] d;
      logic [1:0] p, q;
      nvm_regulator_i = 8'h5f;
      nvm_telemetry_i = 48'hff_03_0000_0000;
      nvm_load_i = 1'b1;
      @(negedge sys_clk_i);
      nvm_load_i = 1'b0;
      @(negedge sys_clk_i);
      chk(regulator_voltage_select_o, 4'h5);
      rd_block(`RTC_CMD_TELEMETRY, 6, c, d);
      chk(d, 48'h00_03_0000_0000);
      next_ch(p);
      repeat (8) begin
         next_ch(q);
         chk(q, 2'(p + 2'h1));
         p = q;
      end
   endtask : t_nvm_all_a

   task t_tiers;
      logic e;
      logic [7:0] c;
      logic [47:0] d;
      logic [1:0] s[16];
      logic [7:0] pat;
      int k;
      pat = 8'b10_00_01_00;
      wr_block(`RTC_CMD_TELEMETRY, 8'h06, 6, 48'hff_03_c0_80_40_01, e);
      chk(e, 1'b0);
      rd_block(`RTC_CMD_TELEMETRY, 6, c, d);
      chk(d, 48'h00_03_c0_80_40_01);
      slow = 1'b1;
      for (int i = 0; i < 16; i++)
         next_ch(s[i]);
      slow = 1'b0;
      k = -1;
      for (int i = 7; i >= 2; i--)
         if (s[i] === 2'h2)
            k = i;
      chk(k >= 0, 1'b1);
      for (int j = 0; j < 8 && k >= 0; j++)
         chk(s[k + 1 + j], pat[2*(j%4) +: 2]);
      chk(read_vin_o, 16'h0000);
      chk(read_vout_o, 16'h0100);
      chk(read_temp_o, 16'h0300);
   endtask : t_tiers

   task t_temp_only;
      logic e;
      logic [1:0] q;
      wr_block(`RTC_CMD_TELEMETRY, 8'h06, 6, 48'h00_03_c0_c0_c0_c0, e);
      chk(e, 1'b0);
      next_ch(q);
      repeat (4) begin
         next_ch(q);
         chk(q, 2'h2);
      end
      chk(read_iout_o, 16'h0000);
   endtask : t_temp_only

   initial begin
      repeat (16) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      @(negedge sys_clk_i);
      t_reset();
      t_regulator();
      t_timeout();
      t_nvm_all_a();
      t_tiers();
      t_temp_only();
      report_and_stop();
   end
endmodule : regulator_and_telemetry_config_bench
`default_nettype wire

// File: verification/rtc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_adc_model (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic slow_i,
   input wire logic adc_start_i,
   input wire logic [1:0] adc_channel_i,
   output logic adc_done_o,
   output logic [15:0] adc_data_o
);
   logic [4:0] wait_cnt;
   logic [1:0] chan;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_cnt <= 5'h00;
         chan <= 2'h0;
         adc_done_o <= 1'b0;
         adc_data_o <= 16'h0000;
      end else begin
         adc_done_o <= 1'b0;
         // data only valid with done, so it churns otherwise
         adc_data_o <= ~adc_data_o;
         if (adc_start_i) begin
            chan <= adc_channel_i;
            wait_cnt <= slow_i ? 5'h0c : 5'h02;
         end else if (wait_cnt == 5'h01) begin
            wait_cnt <= 5'h00;
            adc_done_o <= 1'b1;
            adc_data_o <= {5'h00, {1'b0, chan} + 3'h1, 8'h00};
         end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
         end
      end
   end
endmodule : rtc_adc_model
`default_nettype wire
